// >>> lp_wake_defs.svh
// Constants for the low-power wake-status and regulator block
// Function
// - Logic event in low power sets flag when logicIntEn is set
// - Comparator rising edge in low power sets comparator flag
// - Stop regulator config bit 3, reset 0
// - Config 0 keeps regulator on in stop
// - Stopped active: enabled resets reset device
// - Config 1 shuts regulator, enters shutdown
// - Shutdown exits only by pin or power
// - Snooze halts oscillators, gates clock, low regulator
`ifndef LP_WAKE_DEFS_SVH
`define LP_WAKE_DEFS_SVH
`define WAKE_STATUS_ADDR 8'h00AA
`define REG_CONTROL_ADDR 8'h00C9
`define POWER_CONTROL_ADDR 8'h00CD
`define INT_STATUS_ADDR 8'h00E0
`define INT_MASK_ADDR 8'h00E4
`define MODE_STATUS_ADDR 8'h00E8
`define STOP_CFG_BIT 3
`define SNOOZE_BIT 7
`define SUSPEND_BIT 6
`define STOP_BIT 1
`define WAKE_MASK 8'h003F
`define RESET_BYTE 8'h0000
`define CMP_WAKE_BIT 0
`define LOGIC_WAKE_BIT 5
`endif

// >>> lp_wake_pkg.sv
// Types for the low-power wake-status block
package lp_wake_pkg;
  typedef enum logic [2:0] {
    RUN = 3'b000,
    SUSPEND = 3'b001,
    SNOOZE = 3'b010,
    STOPPED = 3'b011,
    SHUTDOWN = 3'b100
  } pmode_t;
endpackage

// >>> lp_wake_status.sv
// Wake-status flags, power-mode control and stop regulator config
`timescale 1ns/1ps
`include "lp_wake_defs.svh"
module lp_wake_status (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clkEn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Wake event inputs, asynchronous pins, plus the same-domain logicIntEn enable
  input wire logic logicEvt,
  input wire logic logicIntEn,
  input wire logic serialByteEvt,
  input wire logic twowireMatchEvt,
  input wire logic timerEvt,
  input wire logic portMatchEvt,
  input wire logic cmpOut,
  // Reset sources
  input wire logic external_reset_pin_n,
  input wire logic [3:0] resetSrcReq,
  input wire logic [3:0] resetSrcEn,
  // Power controls
  output logic regulatorOn,
  output logic regulatorLowPwr,
  output logic oscHalt,
  output logic sysClkGate,
  output logic deviceResetReq,
  output logic irq
);
  //==================================================================
  // Pin synchronisers
  //==================================================================
  logic [7:0] rawPins;
  logic [7:0] syncPins;
  // Enables are same-domain; only the raw pin levels and the resetSrcReq requests are synchronised
  assign rawPins = {external_reset_pin_n, logicEvt,
    serialByteEvt, twowireMatchEvt, timerEvt, portMatchEvt, cmpOut,
    1'b0};
  sync2 #(.W(8)) u_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .clkEn(clkEn),
    .din(rawPins),
    .dout(syncPins)
  );
  logic [3:0] rstSync;
  sync2 #(.W(4)) u_rsync (
    .core_clk(core_clk),
    .nrst(nrst),
    .clkEn(clkEn),
    .din(resetSrcReq),
    .dout(rstSync)
  );
  wire pinRstN = syncPins[7];
  wire anyRst = |(rstSync & resetSrcEn);

  //==================================================================
  // State
  //==================================================================
  lp_wake_pkg::pmode_t mode_ff, nxt_mode;
  logic [7:0] wake_ff, nxt_wake;
  logic [7:0] regctl_ff, nxt_regctl;
  logic [7:0] intSts_ff, nxt_intSts;
  logic [7:0] intMask_ff;
  logic cmpPrev_ff;
  logic wrPend_ff;
  logic [7:0] addr_ff;

  //==================================================================
  // Bus decode
  //==================================================================
  wire addrPhase = hsel & hready & htrans[1];
  wire wrEn = wrPend_ff;
  wire [7:0] wb = hwdata[7:0];
  wire selWake = addr_ff == `WAKE_STATUS_ADDR;
  wire selReg = addr_ff == `REG_CONTROL_ADDR;
  wire selPwr = addr_ff == `POWER_CONTROL_ADDR;
  wire selISts = addr_ff == `INT_STATUS_ADDR;
  wire selIMsk = addr_ff == `INT_MASK_ADDR;
  wire selMode = addr_ff == `MODE_STATUS_ADDR;

  //==================================================================
  // Wake events
  //==================================================================
  wire lowPwr = mode_ff == lp_wake_pkg::SUSPEND ||
    mode_ff == lp_wake_pkg::SNOOZE;
  wire cmpRise = syncPins[1] & ~cmpPrev_ff;
  logic [7:0] wakeEvt;
  wire logicWake = syncPins[6] & logicIntEn;
  assign wakeEvt = lowPwr ? {2'b00, logicWake, syncPins[5:2], cmpRise}
    : 8'h0000;
  // Set wins over a software write of zero; only writes clear
  assign nxt_wake = ((wrEn && selWake) ? (wb & `WAKE_MASK) : wake_ff)
    | wakeEvt;

  //==================================================================
  // Mode sequencing
  //==================================================================
  wire stopCfg = regctl_ff[`STOP_CFG_BIT];
  wire anyWake = |wakeEvt;
  always_comb begin
    nxt_mode = mode_ff;
    unique case (mode_ff)
      lp_wake_pkg::RUN: begin
        if (wrEn && selPwr && wb[`SNOOZE_BIT])
          nxt_mode = lp_wake_pkg::SNOOZE;
        else if (wrEn && selPwr && wb[`SUSPEND_BIT])
          nxt_mode = lp_wake_pkg::SUSPEND;
        else if (wrEn && selPwr && wb[`STOP_BIT])
          nxt_mode = stopCfg ? lp_wake_pkg::SHUTDOWN
            : lp_wake_pkg::STOPPED;
      end
      lp_wake_pkg::SUSPEND, lp_wake_pkg::SNOOZE: begin
        if (anyWake)
          nxt_mode = lp_wake_pkg::RUN;
      end
      lp_wake_pkg::STOPPED: begin
        if (anyRst || !pinRstN)
          nxt_mode = lp_wake_pkg::RUN;
      end
      lp_wake_pkg::SHUTDOWN: begin
        if (!pinRstN)
          nxt_mode = lp_wake_pkg::RUN;
      end
      default: nxt_mode = lp_wake_pkg::RUN;
    endcase
  end
  wire rstEvt = (mode_ff == lp_wake_pkg::STOPPED && (anyRst || !pinRstN))
    || (mode_ff == lp_wake_pkg::SHUTDOWN && !pinRstN);

  //==================================================================
  // Control register and interrupts
  //==================================================================
  assign nxt_regctl = (wrEn && selReg)
    ? (wb & (8'h0001 << `STOP_CFG_BIT)) : regctl_ff;
  assign nxt_intSts = ((wrEn && selISts) ? (intSts_ff & ~wb) : intSts_ff)
    | wakeEvt;

  //==================================================================
  // Read path
  //==================================================================
  // Read data is selected from the address phase so it stands in the
  // data phase; a write landing in that same cycle is not yet visible
  function automatic logic [7:0] read_mux(
    input logic [7:0] a,
    input logic [7:0] wk,
    input logic [7:0] rg,
    input logic [7:0] pw,
    input logic [7:0] is,
    input logic [7:0] im,
    input logic [7:0] md
  );
    logic [7:0] v;
    v = 8'h0000;
    case (a)
      `WAKE_STATUS_ADDR: v = wk;
      `REG_CONTROL_ADDR: v = rg;
      `POWER_CONTROL_ADDR: v = pw;
      `INT_STATUS_ADDR: v = is;
      `INT_MASK_ADDR: v = im;
      `MODE_STATUS_ADDR: v = md;
      default: v = 8'h0000;
    endcase
    return v;
  endfunction

  wire [7:0] pwrView = {mode_ff == lp_wake_pkg::SNOOZE,
    mode_ff == lp_wake_pkg::SUSPEND, 6'h0001};
  wire [7:0] modeView = {5'h0000, mode_ff};
  logic [7:0] rdByte;
  assign rdByte = read_mux(haddr[7:0], wake_ff, regctl_ff, pwrView,
    intSts_ff, intMask_ff, modeView);
  wire rdAccept = addrPhase & ~hwrite;

  //==================================================================
  // Registers
  //==================================================================
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mode_ff <= lp_wake_pkg::RUN;
    end else if (clkEn) begin
      mode_ff <= nxt_mode;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wake_ff <= `RESET_BYTE;
      intSts_ff <= `RESET_BYTE;
      cmpPrev_ff <= 1'b0;
    end else if (clkEn) begin
      wake_ff <= nxt_wake;
      intSts_ff <= nxt_intSts;
      cmpPrev_ff <= syncPins[1];
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      regctl_ff <= `RESET_BYTE;
      intMask_ff <= `RESET_BYTE;
    end else if (clkEn) begin
      regctl_ff <= nxt_regctl;
      if (wrEn && selIMsk)
        intMask_ff <= wb & `WAKE_MASK;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wrPend_ff <= 1'b0;
      addr_ff <= 8'h0000;
    end else if (clkEn) begin
      wrPend_ff <= addrPhase & hwrite;
      if (addrPhase)
        addr_ff <= haddr[7:0];
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hrdata <= 32'h0000_0000;
    end else if (clkEn) begin
      if (rdAccept)
        hrdata <= {24'h00_0000, rdByte};
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
      deviceResetReq <= 1'b0;
    end else if (clkEn) begin
      irq <= |(nxt_intSts & intMask_ff);
      deviceResetReq <= rstEvt;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      regulatorOn <= 1'b1;
      regulatorLowPwr <= 1'b0;
      oscHalt <= 1'b0;
      sysClkGate <= 1'b0;
    end else if (clkEn) begin
      regulatorOn <= nxt_mode != lp_wake_pkg::SHUTDOWN;
      regulatorLowPwr <= nxt_mode == lp_wake_pkg::SNOOZE;
      oscHalt <= nxt_mode != lp_wake_pkg::RUN;
      sysClkGate <= nxt_mode != lp_wake_pkg::RUN;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
endmodule

// >>> lp_wake_status_assertions.sv
// Port checker for the wake-status and regulator block
`timescale 1ns/1ps
module lp_wake_status_assertions (
  // Clock, reset and bus
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Power side
  input wire logic external_reset_pin_n,
  input wire logic regulatorOn,
  input wire logic regulatorLowPwr,
  input wire logic oscHalt,
  input wire logic sysClkGate,
  input wire logic deviceResetReq
);
  // ==========
  // Properties
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence addrRead; hsel && hready && htrans[1] && !hwrite; endsequence
  no_wait_a: assert property (hreadyout) else $error("wait state");
  okay_resp_a: assert property (!hresp) else $error("error response");
  upper_zero_a: assert property (hrdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  unmapped_zero_a: assert property (addrRead ##0 haddr[7:0] == 8'h10 |=>
    hrdata == 32'h0000_0000) else $error("unmapped read not zero");
  reset_pulse_a: assert property (deviceResetReq |=> !deviceResetReq)
    else $error("reset request too long");
  snooze_gate_a: assert property (regulatorLowPwr |-> oscHalt && sysClkGate)
    else $error("low power without halt");
  halt_gate_a: assert property (oscHalt |-> sysClkGate)
    else $error("halt without gate");
  shut_exit_a: assert property ($rose(regulatorOn) |->
    !$past(external_reset_pin_n, 2) || !$past(external_reset_pin_n, 3) ||
    !$past(external_reset_pin_n, 4)) else $error("shutdown left without pin");
endmodule
bind lp_wake_status lp_wake_status_assertions chk (.*);

// >>> lp_wake_status_bench.sv
// Self-checking bench for the wake-status and regulator block
`timescale 1ns/1ps
module lp_wake_status_bench;
  // ==========
  // Signals
  logic core_clk = 0, nrst = 0, clkEn = 1, hsel = 0, hwrite = 0, hready;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
  logic [2:0] hsize = 3'h2;
  logic [1:0] htrans = 0;
  logic [5:0] evt = 0;
  logic [3:0] resetSrcReq = 0, resetSrcEn = 0;
  logic external_reset_pin_n = 1, logicIntEn = 0, rdTake = 0;
  logic hreadyout, hresp, regulatorOn, regulatorLowPwr, oscHalt, sysClkGate;
  logic deviceResetReq, irq, logicEvt, serialByteEvt, twowireMatchEvt;
  logic timerEvt, portMatchEvt, cmpOut;
  logic [31:0] exq[$];
  int n_mismatch = 0, checked = 0;
  assign {logicEvt, serialByteEvt, twowireMatchEvt, timerEvt, portMatchEvt,
    cmpOut} = evt;
  assign hready = hreadyout;
  always #25 core_clk = ~core_clk;
  lp_wake_status uut (.*);
  // ==========
  // Tasks and monitor
  task cmp(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1; htrans <= 2'b10; haddr <= {24'h00_0000, a}; hwrite <= w;
    do @(posedge core_clk); while (hready !== 1'b1);
    hsel <= 0; htrans <= 0; hwdata <= d; rdTake <= !w;
    do @(posedge core_clk); while (hready !== 1'b1);
    rdTake <= 0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    exq.push_back(e);
    xfer(a, 0, 0);
  endtask
  always @(posedge core_clk) if (rdTake === 1'b1) cmp(hrdata, exq.pop_front());
  task complete_run;
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ==========
  // Tests
  initial begin
    void'($urandom(44023));
    repeat (3) @(posedge core_clk);
    nrst <= 1;
    @(posedge core_clk);
    cmp(regulatorOn, 1);
    rd(8'hAA, 0);
    rd(8'hC9, 0);
    r = $urandom;
    xfer(8'hC9, 1, r);
    rd(8'hC9, {28'h000_0000, r[3], 3'b000});
    rd(8'h10, 0);
    xfer(8'hE4, 1, 32'h0000_003F);
    $display("Test registers done");
    for (int i = 0; i < 6; i++) begin
      logicIntEn <= (i == 5);
      xfer(8'hCD, 1, i[0] ? 32'h0000_0080 : 32'h0000_0040);
      repeat (2) @(posedge core_clk);
      cmp(regulatorLowPwr, i[0]);
      evt[i] <= 1;
      repeat (4) @(posedge core_clk);
      evt[i] <= 0;
      repeat (6) @(posedge core_clk);
      cmp(irq, 1);
      rd(8'hAA, 32'h0000_0001 << i);
      rd(8'hE8, 0);
      xfer(8'hE0, 1, 32'h0000_003F);
      xfer(8'hAA, 1, 0);
      repeat (2) @(posedge core_clk);
      cmp(irq, 0);
      rd(8'hAA, 0);
    end
    $display("Test wake flags done");
    xfer(8'hC9, 1, 0);
    xfer(8'hCD, 1, 32'h0000_0002);
    resetSrcReq <= 4'b0011; resetSrcEn <= 4'b0100;
    repeat (6) @(posedge core_clk);
    cmp(regulatorOn, 1);
    rd(8'hE8, 3);
    resetSrcEn <= 4'b0001;
    repeat (6) @(posedge core_clk);
    rd(8'hE8, 0);
    resetSrcReq <= 0;
    $display("Test stop active done");
    xfer(8'hC9, 1, 32'h0000_0008);
    xfer(8'hCD, 1, 32'h0000_0002);
    repeat (4) @(posedge core_clk);
    cmp(regulatorOn, 0);
    resetSrcReq <= 4'b0001;
    repeat (6) @(posedge core_clk);
    cmp(regulatorOn, 0);
    external_reset_pin_n <= 0;
    repeat (4) @(posedge core_clk);
    external_reset_pin_n <= 1;
    repeat (6) @(posedge core_clk);
    cmp(regulatorOn, 1);
    $display("Test shutdown done");
    complete_run;
  end
  initial begin
    #100us;
    n_mismatch++;
    complete_run;
  end
endmodule

// >>> sync2.sv
// Two-flop synchroniser for a vector of pin-side levels
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 8
) (
  // Clocking
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clkEn,
  // Data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_ff;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      meta_ff <= '0;
      dout <= '0;
    end else if (clkEn) begin
      meta_ff <= din;
      dout <= meta_ff;
    end
  end
endmodule
